// ==== include/sbg_pkg.sv ====
/*
 Shared constants for the servo burst gate control block: power-up
 timing, gate cycle count and width, and the two state enumerations.
 Assumes a single 200 MHz clock (mclk) on both ends.
*/
// Functional notes
// - Carrier toggles on every burst zero crossing
// - Carrier undefined when burst amplitude low
// - Gate asserted enables area measurement
// - Gate resynchronised on carrier rising edges
// - Controller holds gate fixed burst cycles
// - Reset clears gate flop, enables reset amp
// - Controller resets detector before each integration
// - Gain loop enable drives gain amplifier
// - Gain loop enabled after gain integration
// - Low power request biases down circuits
// - Reference stays normal in both modes
// - Low power: outputs undefined, inputs float high
// - Controller may power down between sectors
// - Comparator decision shown on test output
// - Controller waits 5.0 us after wake
// - Integration spans equal whole burst cycles
package sbg_pkg;
    localparam int CLK_PERIOD_PS     = 5000;    // 200 MHz mclk
    localparam int WAKE_TIME_NS      = 5000;    // 5.0 us ready time
    localparam int WAKE_CYCLES       =
        (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE_CNT_W        = 12;
    localparam int GATE_CYCLES_DEF   = 8;       // burst cycles per gate
    localparam int GATE_CNT_W        = 8;
    localparam logic       RST_LOW   = 1'b0;
    typedef enum logic [1:0] {
        SBG_ST_OFF,
        SBG_ST_WAKE,
        SBG_ST_READY
    } sbg_pwr_e;
    typedef enum logic [2:0] {
        SBG_C_IDLE,
        SBG_C_RESET,
        SBG_C_ALIGN,
        SBG_C_GATE,
        SBG_C_AGC,
        SBG_C_SLEEP
    } sbg_ctl_e;
endpackage

// ==== include/sbg_if.sv ====
/*
 Link between the servo burst gate device and its controller.
 Assumes both ends share mclk; digital stand-ins for analog pins.
*/
`timescale 1ns/1ps
interface sbg_if (
    input wire logic mclk               // Shared clock
);
    logic zero_cross_carrier;           // Carrier from comparator
    logic gate;                         // Gate request
    logic reset;                        // Detector reset
    logic gain_loop_enable;             // Gain loop enable
    logic low_power_request;            // Low power mode request
    logic adc_comparator_test_out;      // Converter comparator test
    logic ready;                        // Device biased and ready

    modport device (
        input  gate, reset, gain_loop_enable, low_power_request,
        output zero_cross_carrier, adc_comparator_test_out, ready
    );
    modport ctrl (
        output gate, reset, gain_loop_enable, low_power_request,
        input  zero_cross_carrier, adc_comparator_test_out, ready
    );
endinterface

// ==== rtl/sbg_device.sv ====
/*
 Digital model of the servo burst area detector control: carrier
 toggle, carrier-timed gate resynchronisation, reset and gain loop
 enables, and power-down sequencing.
 Assumes burst zero crossings arrive as a sampled pulse input and
 all link inputs are synchronous to mclk.
*/
`timescale 1ns/1ps
module sbg_device
    import sbg_pkg::*;
(
    input  wire logic mclk,             // System clock
    input  wire logic sys_rst,          // Sync reset, high
    sbg_if.device     lnk,              // Link to controller
    input  wire logic burst_zero_cross, // Burst zero-crossing pulse
    input  wire logic burst_amp_ok,     // Burst amplitude adequate
    input  wire logic adc_cmp_decision, // Converter comparator bit
    output logic      detector_gate,    // Integrator pump enable
    output logic      reset_amp_en,     // Reset amplifier enable
    output logic      gain_amp_en,      // Gain amplifier enable
    output logic      bias_on,          // Bias for non-reference
    output logic      ref_on            // Bandgap reference enable
);
    logic      zero_cross_carrier_r, zero_cross_carrier_nxt;
    logic      gsync_r, gsync_nxt;
    logic      rst_r, rst_nxt;
    logic      agc_r, agc_nxt;
    logic      bias_r, bias_nxt;
    logic      cmp_r, cmp_nxt;
    logic      rdy_r, rdy_nxt;
    sbg_pwr_e  pwr_r, pwr_nxt;
    logic [WAKE_CNT_W-1:0] wcnt_r, wcnt_nxt;
    logic      zero_cross_carrier_rise;

    // Rising carrier edge, one per burst cycle while bias_r and burst_amp_ok are high
    assign zero_cross_carrier_rise = burst_zero_cross && !zero_cross_carrier_r && bias_r;

    // Carrier, gate flop and enables
    always_comb begin
        zero_cross_carrier_nxt = zero_cross_carrier_r;
        if (burst_zero_cross && bias_r) begin
            zero_cross_carrier_nxt = !zero_cross_carrier_r;
        end
        // Low amplitude: carrier held, edges not trusted
        if (!burst_amp_ok) begin
            zero_cross_carrier_nxt = zero_cross_carrier_r;
        end
        gsync_nxt = gsync_r;
        if (zero_cross_carrier_rise && burst_amp_ok) begin
            gsync_nxt = lnk.gate;
        end
        // Reset overrides the carrier-timed capture
        if (lnk.reset) begin
            gsync_nxt = 1'b0;
        end
        rst_nxt  = lnk.reset && bias_r;
        agc_nxt  = lnk.gain_loop_enable && bias_r;
        cmp_nxt  = adc_cmp_decision && bias_r;
    end

    // Power mode sequencing
    always_comb begin
        pwr_nxt  = pwr_r;
        wcnt_nxt = wcnt_r;
        case (pwr_r)
            SBG_ST_OFF: begin
                wcnt_nxt = '0;
                if (!lnk.low_power_request) begin
                    pwr_nxt = SBG_ST_WAKE;
                end
            end
            SBG_ST_WAKE: begin
                wcnt_nxt = wcnt_r + 1'b1;
                if (lnk.low_power_request) begin
                    pwr_nxt = SBG_ST_OFF;
                end else if (wcnt_r == WAKE_CNT_W'(WAKE_CYCLES - 1)) begin
                    pwr_nxt = SBG_ST_READY;
                end
            end
            SBG_ST_READY: begin
                if (lnk.low_power_request) begin
                    pwr_nxt = SBG_ST_OFF;
                end
            end
            default: pwr_nxt = SBG_ST_OFF;
        endcase
        // Bias drops at once; reference never does
        bias_nxt = !lnk.low_power_request;
        rdy_nxt  = (pwr_nxt == SBG_ST_READY);
    end

    // Registers; synchronous reset keeps one clock domain
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            zero_cross_carrier_r  <= RST_LOW;
            gsync_r <= RST_LOW;
            rst_r   <= RST_LOW;
            agc_r   <= RST_LOW;
            bias_r  <= RST_LOW;
            cmp_r   <= RST_LOW;
            rdy_r   <= RST_LOW;
            pwr_r   <= SBG_ST_OFF;
            wcnt_r  <= '0;
        end else begin
            zero_cross_carrier_r  <= zero_cross_carrier_nxt;
            gsync_r <= gsync_nxt;
            rst_r   <= rst_nxt;
            agc_r   <= agc_nxt;
            bias_r  <= bias_nxt;
            cmp_r   <= cmp_nxt;
            rdy_r   <= rdy_nxt;
            pwr_r   <= pwr_nxt;
            wcnt_r  <= wcnt_nxt;
        end
    end

    // Outputs; while biased down the carrier and gate flop hold, ref_on stays high, the rest are low
    assign lnk.zero_cross_carrier      = zero_cross_carrier_r;
    assign lnk.adc_comparator_test_out = cmp_r;
    assign lnk.ready                   = rdy_r;
    assign detector_gate = gsync_r;
    assign reset_amp_en  = rst_r;
    assign gain_amp_en   = agc_r;
    assign bias_on       = bias_r;
    // Reference enable tracks only system reset
    always_ff @(posedge mclk) begin
        ref_on <= !sys_rst;
    end
endmodule

// ==== rtl/sbg_ctrl.sv ====
/*
 External servo controller end: sequences reset, gate for a fixed
 count of carrier cycles, then gain loop enable, and sleeps between
 sectors on request.
 Assumes the device drives the carrier and ready on the shared link.
*/
`timescale 1ns/1ps
module sbg_ctrl
    import sbg_pkg::*;
(
    input  wire logic mclk,             // System clock
    input  wire logic sys_rst,          // Sync reset, high
    sbg_if.ctrl       lnk,              // Link to device
    input  wire logic measure_req,      // Pulse: start one burst
    input  wire logic sleep_req,        // Level: idle between sectors
    input  wire logic [GATE_CNT_W-1:0] gate_cycles, // Burst cycles
    output logic      measure_done      // Pulse: burst measured
);
    sbg_ctl_e st_r, st_nxt;
    logic [GATE_CNT_W-1:0] cnt_r, cnt_nxt;
    logic zero_cross_carrier_d_r, zero_cross_carrier_d_nxt;
    logic gate_r, gate_nxt, rst_r, rst_nxt, agc_r, agc_nxt;
    logic lp_r, lp_nxt, done_r, done_nxt;
    logic rise;

    assign rise = lnk.zero_cross_carrier && !zero_cross_carrier_d_r;

    // Measurement sequencer
    always_comb begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        zero_cross_carrier_d_nxt = lnk.zero_cross_carrier;
        gate_nxt   = 1'b0;
        rst_nxt    = 1'b0;
        agc_nxt    = 1'b0;
        lp_nxt     = 1'b0;
        done_nxt   = 1'b0;
        case (st_r)
            SBG_C_IDLE: begin
                if (sleep_req) begin
                    st_nxt = SBG_C_SLEEP;
                    lp_nxt = 1'b1;
                end else if (measure_req && lnk.ready) begin
                    st_nxt  = SBG_C_RESET;
                    rst_nxt = 1'b1;
                end
            end
            SBG_C_RESET: begin
                st_nxt = SBG_C_ALIGN;           // One cycle of reset
            end
            SBG_C_ALIGN: begin
                cnt_nxt = '0;
                if (rise) begin
                    st_nxt   = SBG_C_GATE;
                    gate_nxt = 1'b1;
                end
            end
            SBG_C_GATE: begin
                // Gate drops at the count; one more rising carrier lets
                // the device flop drop before the gain loop
                gate_nxt = (cnt_r != gate_cycles);
                if (rise) begin
                    cnt_nxt = cnt_r + 1'b1;
                    // Same count of cycles every burst
                    if (cnt_r + 1'b1 == gate_cycles) begin
                        gate_nxt = 1'b0;
                    end
                    if (cnt_r == gate_cycles) begin
                        st_nxt = SBG_C_AGC;
                    end
                end
            end
            SBG_C_AGC: begin
                agc_nxt  = 1'b1;
                done_nxt = 1'b1;
                st_nxt   = SBG_C_IDLE;
            end
            SBG_C_SLEEP: begin
                lp_nxt = sleep_req;
                if (!sleep_req) begin
                    st_nxt = SBG_C_IDLE;
                end
            end
            default: st_nxt = SBG_C_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r     <= SBG_C_IDLE;
            cnt_r    <= '0;
            zero_cross_carrier_d_r <= RST_LOW;
            gate_r   <= RST_LOW;
            rst_r    <= RST_LOW;
            agc_r    <= RST_LOW;
            lp_r     <= RST_LOW;
            done_r   <= RST_LOW;
        end else begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            zero_cross_carrier_d_r <= zero_cross_carrier_d_nxt;
            gate_r   <= gate_nxt;
            rst_r    <= rst_nxt;
            agc_r    <= agc_nxt;
            lp_r     <= lp_nxt;
            done_r   <= done_nxt;
        end
    end

    assign lnk.gate              = gate_r;
    assign lnk.reset             = rst_r;
    assign lnk.gain_loop_enable  = agc_r;
    assign lnk.low_power_request = lp_r;
    assign measure_done          = done_r;
endmodule

// ==== testbench/sbg_link_checker.sv ====
/* Assertions on the device-controller link signals.
   Assumes one clock mclk and synchronous reset sys_rst. */
`timescale 1ns/1ps
module sbg_link_checker
    import sbg_pkg::*;
(
    input wire logic                  mclk,                    // Clock
    input wire logic                  sys_rst,                 // Reset
    input wire logic                  zero_cross_carrier,      // Carrier
    input wire logic                  gate,                    // Gate
    input wire logic                  reset,                   // Clear
    input wire logic                  gain_loop_enable,        // Gain
    input wire logic                  low_power_request,       // Sleep
    input wire logic                  adc_comparator_test_out, // Test
    input wire logic                  ready,                   // Ready
    input wire logic [GATE_CNT_W-1:0] gate_cycles              // Length
);
    logic [10:0] awake_r, awake_nxt;
    logic [7:0]  rises_r, rises_nxt;
    logic        clr_r, clr_nxt, car_r;

    // Awake count saturates so a long idle never wraps it
    always_comb begin
        awake_nxt = low_power_request ? '0 : awake_r + {10'h0, ~&awake_r};
        rises_nxt = !gate ? '0 : rises_r + {7'h0, zero_cross_carrier & ~car_r};
        clr_nxt   = reset | (clr_r & ~gate);
    end

    // Registers only
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            awake_r <= '0;
            rises_r <= '0;
            clr_r   <= 1'b0;
        end else begin
            awake_r <= awake_nxt;
            rises_r <= rises_nxt;
            clr_r   <= clr_nxt;
        end
        car_r <= zero_cross_carrier;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_sleep_drops_ready: assert property (
        low_power_request |=> !ready)
        else $error("ready high in sleep");
    a_wake_time_kept: assert property (
        $rose(ready) |-> awake_r >= 11'(WAKE_CYCLES))
        else $error("ready too soon");
    a_gate_len_fixed: assert property (
        $fell(gate) |-> rises_r == gate_cycles)
        else $error("gate length wrong");
    a_reset_before_gate: assert property (
        $rose(gate) |-> clr_r)
        else $error("gate without clear");
    a_start_when_ready: assert property (
        $rose(reset) |-> ready)
        else $error("start while not ready");
    a_gain_after_gate: assert property (
        gain_loop_enable |-> !gate && !reset)
        else $error("gain loop too early");
    a_gain_one_pulse: assert property (
        gain_loop_enable |=> !gain_loop_enable)
        else $error("gain loop too long");
    a_sleep_when_idle: assert property (
        low_power_request |-> !gate)
        else $error("sleep mid burst");
    a_sleep_holds_carrier: assert property (
        low_power_request && $past(low_power_request)
        |=> $stable(zero_cross_carrier))
        else $error("carrier moved in sleep");
    a_test_out_sleeps: assert property (
        low_power_request && $past(low_power_request)
        |=> !adc_comparator_test_out)
        else $error("test output live in sleep");
endmodule

// ==== testbench/testbench.sv ====
/* Bench: controller and device joined by the link.
   Assumes 200 MHz mclk and a zero crossing every 4 cycles. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; \
    if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench
    import sbg_pkg::*;
;
    typedef struct {logic [7:0] gc; int len;} sbg_row_s;
    sbg_row_s   rows[3] = '{'{8'h01, 8}, '{8'h03, 24}, '{8'h08, 64}};
    logic       mclk, sys_rst, measure_req, sleep_req, burst_amp_ok;
    logic       adc_cmp_decision, measure_done, detector_gate, car_q;
    logic       reset_amp_en, gain_amp_en, bias_on, ref_on;
    logic       burst_zero_cross = 1'b0;
    logic [7:0] gate_cycles;
    logic [1:0] ph = 2'h0;
    int         num_errors, comparisons, dg_n, ra_n, ga_n, tg_n, md_n, ov_n;
    int         k, d, r, g, t;

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    sbg_if link (.mclk(mclk));
    sbg_device sbg_device_inst (.mclk(mclk), .sys_rst(sys_rst), .lnk(link),
        .burst_zero_cross(burst_zero_cross), .burst_amp_ok(burst_amp_ok),
        .adc_cmp_decision(adc_cmp_decision), .detector_gate(detector_gate),
        .reset_amp_en(reset_amp_en), .gain_amp_en(gain_amp_en),
        .bias_on(bias_on), .ref_on(ref_on));
    sbg_ctrl sbg_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst), .lnk(link),
        .measure_req(measure_req), .sleep_req(sleep_req),
        .gate_cycles(gate_cycles), .measure_done(measure_done));
    sbg_link_checker chk_inst (.mclk(mclk), .sys_rst(sys_rst),
        .zero_cross_carrier(link.zero_cross_carrier), .gate(link.gate),
        .reset(link.reset), .gain_loop_enable(link.gain_loop_enable),
        .low_power_request(link.low_power_request),
        .adc_comparator_test_out(link.adc_comparator_test_out),
        .ready(link.ready), .gate_cycles(gate_cycles));

    // Crossing every 4 cycles; counters only ever grow, tests use deltas
    always @(posedge mclk) begin
        ph <= ph + 2'h1;
        burst_zero_cross <= (ph == 2'h3);
        car_q <= link.zero_cross_carrier;
        dg_n <= dg_n + int'(detector_gate === 1'b1);
        ra_n <= ra_n + int'(reset_amp_en === 1'b1);
        ga_n <= ga_n + int'(gain_amp_en === 1'b1);
        md_n <= md_n + int'(measure_done === 1'b1);
        tg_n <= tg_n + int'(link.zero_cross_carrier !== car_q);
        // Gain loop must never run while the detector integrates
        ov_n <= ov_n + int'(gain_amp_en === 1'b1 && detector_gate === 1'b1);
    end

    task automatic wrap_up();
        $display("num_errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wait_ready(output int n);
        for (n = 0; n < 1200 && link.ready !== 1'b1; n++) @(posedge mclk);
        if (n == 1200) begin num_errors++; wrap_up(); end
    endtask

    // Request one burst; busy wait is bounded
    task automatic measure(input logic [7:0] gc);
        int n;
        gate_cycles <= gc;
        measure_req <= 1'b1;
        @(posedge mclk);
        measure_req <= 1'b0;
        for (n = 0; n < 2000 && measure_done !== 1'b1; n++) @(posedge mclk);
        if (n == 2000) begin num_errors++; wrap_up(); end
        repeat (4) @(posedge mclk);
    endtask

    initial begin
        sys_rst <= 1'b1;
        measure_req <= 1'b0;
        sleep_req <= 1'b0;
        burst_amp_ok <= 1'b1;
        adc_cmp_decision <= 1'b0;
        gate_cycles <= 8'h01;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        wait_ready(k);
        foreach (rows[i]) begin
            d = dg_n;
            r = ra_n;
            g = ga_n;
            measure(rows[i].gc);
            `CHK("gate_len", rows[i].len, dg_n - d)
            `CHK("reset_amp", 1, ra_n - r)
            `CHK("gain_amp", 1, ga_n - g)
        end
        `CHK("gain_overlap", 0, ov_n)
        t = tg_n;
        repeat (40) @(posedge mclk);
        `CHK("toggles", 10, tg_n - t)
        burst_amp_ok <= 1'b0;
        repeat (2) @(posedge mclk);
        t = tg_n;
        repeat (40) @(posedge mclk);
        `CHK("held", 0, tg_n - t)
        burst_amp_ok <= 1'b1;
        adc_cmp_decision <= 1'b1;
        repeat (3) @(posedge mclk);
        `CHK("test_out", 1'b1, link.adc_comparator_test_out)
        sleep_req <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK("ready", 1'b0, link.ready)
        `CHK("bias", 1'b0, bias_on)
        `CHK("ref", 1'b1, ref_on)
        `CHK("test_off", 1'b0, link.adc_comparator_test_out)
        t = md_n;
        measure_req <= 1'b1;
        @(posedge mclk);
        measure_req <= 1'b0;
        repeat (20) @(posedge mclk);
        `CHK("refused", 0, md_n - t)
        sleep_req <= 1'b0;
        wait_ready(k);
        `CHK("wake", 1'b1, k >= WAKE_CYCLES)
        measure_req <= 1'b1;
        @(posedge mclk);
        measure_req <= 1'b0;
        repeat (30) @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        `CHK("gate_clr", 1'b0, detector_gate)
        sys_rst <= 1'b0;
        wait_ready(k);
        wrap_up();
    end
endmodule
